// File: logic/card_capability_classifier.sv
`timescale 1ns/1ps

module card_capability_classifier (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] card_capability_sense,
  output logic      [2:0] capability_code
);

  logic [2:0] candidate;
  logic [slot_power_pkg::CAP_COUNT_WIDTH-1:0] stable_count;

  // Only the five resolvable levels are legal; anything else is ignored.
  function automatic logic level_is_legal(input logic [2:0] level);
    return level < 3'(slot_power_pkg::CAP_LEVELS);
  endfunction : level_is_legal

  // A level is reported only after it has stayed put, so a card still
  // seating in the connector does not flash a wrong capability.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      candidate    <= slot_power_pkg::CAP_CODE_RESET;
      stable_count <= '0;
    end else if (level_is_legal(card_capability_sense) &&
                 card_capability_sense != candidate) begin
      candidate    <= card_capability_sense;
      stable_count <= '0;
    end else if (stable_count !=
                 slot_power_pkg::CAP_COUNT_WIDTH'(
                   slot_power_pkg::CAP_STABLE_CYCLES)) begin
      stable_count <= stable_count + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capability_code <= slot_power_pkg::CAP_CODE_RESET;
    end else if (stable_count ==
                 slot_power_pkg::CAP_COUNT_WIDTH'(
                   slot_power_pkg::CAP_STABLE_CYCLES)) begin
      capability_code <= candidate;
    end
  end

endmodule : card_capability_classifier

// File: logic/hot_plug_slot_power_control.sv
// How it works
// - The power indicator drive is low while its enable is high, else high.
// - The attention indicator drive is low while its enable is high.
// - IO select high picks the 3.3 V IO gate, low picks the 1.5 V gate.
// - Aux switch high enables aux power; while low the aux fault clears.
// - Main enable high turns on main power; low clears fault, asserts UV.
// - The discharged status is low only when every slot output is empty.
// - The card capability is classified from a five-level detector.
// - The capability code leaves as three single-bit outputs, bits 1 to 3.
// - The undervoltage output is low while main rails are out of range.
// - The aux fault output is low while an aux supply fault exists.
// - The main fault output is low while a main power fault exists.
// - The 12 V output is on when enabled and discharged when off or faulted.
// - The -12 V output follows the 12 V output on and off together.
// - The event switch closes after aux is good, opens on aux fault or off.
`timescale 1ns/1ps

module hot_plug_slot_power_control (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  power_indicator_enable,
  input  wire logic                  attention_indicator_enable,
  input  wire logic                  io_voltage_select,
  input  wire logic                  aux_power_switch,
  input  wire logic                  main_power_enable,
  input  wire logic                  system_power_good,
  input  wire logic [2:0]            card_capability_sense,
  input  wire logic                  main_overcurrent,
  input  wire logic                  aux_overcurrent,
  input  wire logic                  aux_voltage_good,
  input  wire logic                  main_rails_in_range,
  input  wire logic [5:0]            rail_discharged,
  output logic                       power_indicator_drive,
  output logic                       attention_indicator_drive,
  output logic                       io_33_gate_enable,
  output logic                       io_15_gate_enable,
  output logic                       aux_power_enable,
  output logic                       main_gate_enable,
  output logic                       plus12_slot_output,
  output logic                       minus12_slot_output,
  output logic                       rail_discharge_enable,
  output logic                       power_discharged_status,
  output logic                       output_undervoltage_n,
  output logic                       aux_fault_n,
  output logic                       main_fault_n,
  output logic                       slot_event_bus_output,
  output logic                       card_capability_bit1,
  output logic                       card_capability_bit2,
  output logic                       card_capability_bit3
);

  typedef enum logic [1:0] {
    IO_OFF,
    IO_DEAD,
    IO_HIGH,
    IO_LOW
  } io_state_e;

  io_state_e  io_state;
  io_state_e  next_io_state;
  logic       main_fault;
  logic       aux_fault;
  logic       main_on;
  logic       next_main_on;
  logic       io_target_high;
  logic [2:0] capability_code;
  logic [5:0] rail_empty;
  logic [slot_power_pkg::DEAD_COUNT_WIDTH-1:0] dead_count;

  // Indicator drives follow their enables, inverted for an active-low LED.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_indicator_drive     <= slot_power_pkg::STATUS_RELEASED;
      attention_indicator_drive <= slot_power_pkg::STATUS_RELEASED;
    end else begin
      power_indicator_drive     <= ~power_indicator_enable;
      attention_indicator_drive <= ~attention_indicator_enable;
    end
  end

  // Aux power and its fault latch; a new fault beats the clear.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aux_fault        <= 1'b0;
      aux_power_enable <= 1'b0;
    end else begin
      aux_fault <= aux_overcurrent | (aux_fault & aux_power_switch);
      aux_power_enable <= aux_power_switch & ~aux_fault & ~aux_overcurrent;
    end
  end

  // The main fault latches and clears only when main enable is low; an
  // overcurrent in the same cycle as the clear still sets it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_fault <= 1'b0;
    end else begin
      main_fault <= main_overcurrent | (main_fault & main_power_enable);
    end
  end

  // Power good is trusted as given; the slot never powers without it.
  assign next_main_on = main_power_enable & system_power_good
                        & ~main_fault & ~main_overcurrent;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_on               <= 1'b0;
      main_gate_enable      <= 1'b0;
      plus12_slot_output    <= 1'b0;
      minus12_slot_output   <= 1'b0;
      rail_discharge_enable <= 1'b1;
    end else begin
      main_on               <= next_main_on;
      main_gate_enable      <= next_main_on;
      plus12_slot_output    <= next_main_on;
      minus12_slot_output   <= next_main_on;
      rail_discharge_enable <= ~next_main_on;
    end
  end

  // The two IO gates are never on together: a change of selection passes
  // through a dead time, trading a short IO gap for no shoot-through.
  assign io_target_high = io_voltage_select;

  always_comb begin
    next_io_state = io_state;
    unique case (io_state)
      IO_OFF: begin
        if (main_on) begin
          next_io_state = IO_DEAD;
        end
      end
      IO_DEAD: begin
        if (!main_on) begin
          next_io_state = IO_OFF;
        end else if (dead_count ==
                     slot_power_pkg::DEAD_COUNT_WIDTH'(
                       slot_power_pkg::IO_DEAD_CYCLES - 1)) begin
          next_io_state = io_target_high ? IO_HIGH : IO_LOW;
        end
      end
      IO_HIGH: begin
        if (!main_on) begin
          next_io_state = IO_OFF;
        end else if (!io_target_high) begin
          next_io_state = IO_DEAD;
        end
      end
      IO_LOW: begin
        if (!main_on) begin
          next_io_state = IO_OFF;
        end else if (io_target_high) begin
          next_io_state = IO_DEAD;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_state <= IO_OFF;
    end else begin
      io_state <= next_io_state;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dead_count <= '0;
    end else if (io_state == IO_DEAD && next_io_state == IO_DEAD) begin
      dead_count <= dead_count + 1'b1;
    end else begin
      dead_count <= '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_33_gate_enable <= 1'b0;
      io_15_gate_enable <= 1'b0;
    end else begin
      io_33_gate_enable <= (next_io_state == IO_HIGH);
      io_15_gate_enable <= (next_io_state == IO_LOW);
    end
  end

  // Each rail must read discharged for a settle time so that a sense
  // comparator crossing on a slow ramp does not report empty too early.
  for (genvar rail = 0; rail < slot_power_pkg::RAIL_COUNT; rail++)
  begin : g_rail
    logic [slot_power_pkg::SETTLE_COUNT_WIDTH-1:0] settle;
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        settle           <= '0;
        rail_empty[rail] <= 1'b0;
      end else if (!rail_discharged[rail]) begin
        settle           <= '0;
        rail_empty[rail] <= 1'b0;
      end else if (settle ==
                   slot_power_pkg::SETTLE_COUNT_WIDTH'(
                     slot_power_pkg::DISCHARGE_SETTLE_CYCLES - 1)) begin
        rail_empty[rail] <= 1'b1;
      end else begin
        settle <= settle + 1'b1;
      end
    end
  end

  // Status outputs, all active low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_discharged_status <= slot_power_pkg::STATUS_RELEASED;
      output_undervoltage_n   <= slot_power_pkg::STATUS_ASSERTED;
      aux_fault_n             <= slot_power_pkg::STATUS_RELEASED;
      main_fault_n            <= slot_power_pkg::STATUS_RELEASED;
    end else begin
      power_discharged_status <= ~(&rail_empty);
      output_undervoltage_n   <= main_power_enable & main_on
                                 & main_rails_in_range;
      aux_fault_n             <= ~aux_fault;
      main_fault_n            <= ~main_fault;
    end
  end

  // The event switch opens at once on an aux fault or a switch release and
  // recloses only after aux has come back good.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_event_bus_output <= 1'b0;
    end else begin
      slot_event_bus_output <= aux_power_switch & aux_voltage_good
                               & ~aux_fault & ~aux_overcurrent;
    end
  end

  card_capability_classifier u_capability (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .card_capability_sense (card_capability_sense),
    .capability_code       (capability_code)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      card_capability_bit1 <= 1'b0;
      card_capability_bit2 <= 1'b0;
      card_capability_bit3 <= 1'b0;
    end else begin
      card_capability_bit1 <= capability_code[0];
      card_capability_bit2 <= capability_code[1];
      card_capability_bit3 <= capability_code[2];
    end
  end

  chk_power_indicator: assert property (
    @(posedge clock) disable iff (!rst_n)
    power_indicator_enable |=> !power_indicator_drive)
    else $error("power indicator not lit after enable");

  chk_attention_indicator: assert property (
    @(posedge clock) disable iff (!rst_n)
    !attention_indicator_enable |=> attention_indicator_drive)
    else $error("attention indicator lit without enable");

  chk_io_gates_exclusive: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(io_33_gate_enable && io_15_gate_enable))
    else $error("both IO gates on");

  chk_io_select_follow: assert property (
    @(posedge clock) disable iff (!rst_n)
    io_33_gate_enable && !io_voltage_select && main_on
    |=> !io_33_gate_enable ##[1:250] io_15_gate_enable || !main_on)
    else $error("IO select change not followed");

  chk_power_good_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    !system_power_good |=> !main_gate_enable && !plus12_slot_output)
    else $error("main power on without power good");

  chk_main_fault_latch: assert property (
    @(posedge clock) disable iff (!rst_n)
    main_fault && main_power_enable |=> ##1 !main_fault_n)
    else $error("main fault released while enabled");

  chk_main_fault_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    !main_power_enable && !main_overcurrent ##1 !main_power_enable
    |=> main_fault_n && !output_undervoltage_n)
    else $error("enable low did not clear fault and assert UV");

  chk_twelve_tracking: assert property (
    @(posedge clock) disable iff (!rst_n)
    plus12_slot_output == minus12_slot_output &&
    rail_discharge_enable == !plus12_slot_output)
    else $error("negative rail not tracking positive rail");

  chk_fault_discharges: assert property (
    @(posedge clock) disable iff (!rst_n)
    main_overcurrent |=> rail_discharge_enable ##1 !main_fault_n)
    else $error("main fault did not discharge outputs");

  chk_aux_fault_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(aux_power_switch || aux_overcurrent) [*2]
    |=> aux_fault_n && !aux_power_enable)
    else $error("aux fault not cleared by switch low");

  chk_event_switch_open: assert property (
    @(posedge clock) disable iff (!rst_n)
    aux_overcurrent || !aux_power_switch || !aux_voltage_good
    |=> !slot_event_bus_output)
    else $error("event switch not opened");

  chk_discharged_status: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(&rail_discharged) |=> ##1 power_discharged_status)
    else $error("discharged status low with a live rail");

endmodule : hot_plug_slot_power_control

// File: logic/slot_power_pkg.sv
package slot_power_pkg;

  // Clock period used to turn times into cycle counts.
  localparam int CLOCK_PERIOD_NS = 5;

  // Break-before-make gap between the two IO supply gate drives.
  localparam int IO_DEAD_TIME_NS = 1000;
  localparam int IO_DEAD_CYCLES  =
    (IO_DEAD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // A capability level must hold this long before it is reported.
  localparam int CAP_STABLE_NS     = 100;
  localparam int CAP_STABLE_CYCLES =
    (CAP_STABLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // A rail must read as discharged this long before it counts as empty.
  localparam int DISCHARGE_SETTLE_NS     = 50;
  localparam int DISCHARGE_SETTLE_CYCLES =
    (DISCHARGE_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Number of slot power outputs watched for discharge.
  localparam int RAIL_COUNT = 6;

  // Detector levels and code width.
  localparam int          CAP_LEVELS      = 5;
  localparam int          CAP_CODE_WIDTH  = 3;
  localparam logic [2:0]  CAP_CODE_RESET  = 3'h0;

  // Counter widths sized for the cycle counts above.
  localparam int DEAD_COUNT_WIDTH   = 8;
  localparam int CAP_COUNT_WIDTH    = 5;
  localparam int SETTLE_COUNT_WIDTH = 4;

  // Output values after reset.
  localparam logic STATUS_RELEASED = 1'b1;
  localparam logic STATUS_ASSERTED = 1'b0;

endpackage : slot_power_pkg

// File: sim/hot_plug_slot_power_control_tb.sv
`timescale 1ns/1ps

module hot_plug_slot_power_control_tb;
  typedef enum int {pled, aled, io33, io15, auxe, mgate, p12, m12, dise,
                    poff, uv, auxf, mflt, evt, c0, c1, c2} out_e;
  typedef struct {
    int   idx;
    logic exp;
    int   due;
  } note_s;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  want = 5'h00;
  logic        sv = 1'b0;
  logic        pie, aie, ios, aps, mpe, spg;
  logic [2:0]  sense = 3'h0;
  logic        moc = 1'b0;
  logic        aoc = 1'b0;
  logic        avg = 1'b0;
  logic        rng = 1'b0;
  logic [5:0]  rails = 6'h00;
  logic [16:0] obs;
  note_s       notes[$];
  note_s       n;
  int          cyc = 0;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  slot_host_model host (
    .clock(clock), .rst_n(rst_n), .want(want), .supplies_valid(sv),
    .power_indicator_enable(pie), .attention_indicator_enable(aie),
    .io_voltage_select(ios), .aux_power_switch(aps),
    .main_power_enable(mpe), .system_power_good(spg));

  hot_plug_slot_power_control dut (
    .clock(clock), .rst_n(rst_n), .power_indicator_enable(pie),
    .attention_indicator_enable(aie), .io_voltage_select(ios),
    .aux_power_switch(aps), .main_power_enable(mpe),
    .system_power_good(spg), .card_capability_sense(sense),
    .main_overcurrent(moc), .aux_overcurrent(aoc),
    .aux_voltage_good(avg), .main_rails_in_range(rng),
    .rail_discharged(rails), .power_indicator_drive(obs[0]),
    .attention_indicator_drive(obs[1]), .io_33_gate_enable(obs[2]),
    .io_15_gate_enable(obs[3]), .aux_power_enable(obs[4]),
    .main_gate_enable(obs[5]), .plus12_slot_output(obs[6]),
    .minus12_slot_output(obs[7]), .rail_discharge_enable(obs[8]),
    .power_discharged_status(obs[9]), .output_undervoltage_n(obs[10]),
    .aux_fault_n(obs[11]), .main_fault_n(obs[12]),
    .slot_event_bus_output(obs[13]), .card_capability_bit1(obs[14]),
    .card_capability_bit2(obs[15]), .card_capability_bit3(obs[16]));

  // Notes are taken in due order; a level output must still hold then.
  always @(negedge clock) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      samples_checked++;
      if (obs[n.idx] !== n.exp) begin
        num_errors++;
        $display("mismatch at %0t: output %0d expected %b",
                 $time, n.idx, n.exp);
      end
    end
  end

  task automatic step(input int cycles);
    repeat (cycles) @(posedge clock);
    #1;
  endtask : step

  task automatic chk(input out_e w, input logic v, input int lat);
    notes.push_back('{int'(w), v, cyc + lat});
  endtask : chk

  task automatic ctl(input logic [4:0] v);
    want = v;
    step(1);
  endtask : ctl

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    logic [1:0] v;
    int         r;
    void'($urandom(17708));
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk(uv, 1'b0, 0);
    chk(dise, 1'b1, 0);
    chk(mflt, 1'b1, 0);
    step(1);
    for (int i = 0; i < 6; i++) begin
      v = 2'($urandom());
      ctl({3'h0, v});
      chk(pled, ~v[0], 1);
      chk(aled, ~v[1], 1);
      step(2);
    end
    $display("test indicators done");
    rng = 1'b1;
    ctl(5'h10);
    chk(p12, 1'b0, 3);
    chk(mgate, 1'b0, 3);
    step(4);
    sv = 1'b1;
    ctl(5'h10);
    chk(mgate, 1'b1, 1);
    chk(p12, 1'b1, 1);
    chk(m12, 1'b1, 1);
    chk(dise, 1'b0, 1);
    chk(uv, 1'b1, 2);
    step(3);
    rng = 1'b0;
    chk(uv, 1'b0, 3);
    step(4);
    rng = 1'b1;
    chk(uv, 1'b1, 3);
    step(4);
    sv = 1'b0;
    ctl(5'h10);
    chk(p12, 1'b0, 2);
    step(3);
    sv = 1'b1;
    ctl(5'h10);
    step(3);
    $display("test main power done");
    moc = 1'b1;
    chk(p12, 1'b0, 1);
    chk(m12, 1'b0, 1);
    chk(mflt, 1'b0, 2);
    step(1);
    moc = 1'b0;
    chk(mflt, 1'b0, 8);
    chk(p12, 1'b0, 8);
    step(9);
    ctl(5'h00);
    chk(mflt, 1'b1, 3);
    chk(uv, 1'b0, 3);
    step(4);
    ctl(5'h10);
    chk(p12, 1'b1, 1);
    step(3);
    $display("test main fault done");
    ctl(5'h14);
    chk(io33, 1'b0, 150);
    chk(io33, 1'b1, 205);
    chk(io15, 1'b0, 205);
    step(206);
    ctl(5'h10);
    chk(io33, 1'b0, 3);
    chk(io15, 1'b0, 150);
    chk(io15, 1'b1, 205);
    step(206);
    $display("test io select done");
    ctl(5'h18);
    chk(auxe, 1'b1, 1);
    chk(evt, 1'b0, 3);
    step(4);
    avg = 1'b1;
    chk(evt, 1'b1, 2);
    step(3);
    aoc = 1'b1;
    chk(evt, 1'b0, 2);
    chk(auxf, 1'b0, 3);
    step(1);
    aoc = 1'b0;
    chk(auxf, 1'b0, 6);
    chk(auxe, 1'b0, 6);
    step(7);
    ctl(5'h10);
    chk(auxf, 1'b1, 3);
    chk(evt, 1'b0, 3);
    step(4);
    $display("test aux done");
    ctl(5'h00);
    rails = 6'h3f;
    chk(poff, 1'b1, 5);
    chk(poff, 1'b0, 14);
    step(15);
    r = $urandom_range(5, 0);
    rails[r] = 1'b0;
    chk(poff, 1'b1, 3);
    step(4);
    $display("test discharge done");
    for (int lv = 0; lv < 5; lv++) begin
      sense = 3'(lv);
      chk(c0, sense[0], 25);
      chk(c1, sense[1], 25);
      chk(c2, sense[2], 25);
      step(26);
    end
    sense = 3'(5 + $urandom_range(2, 0));
    chk(c0, 1'b0, 25);
    chk(c2, 1'b1, 25);
    step(26);
    $display("test capability done");
    for (int i = 0; i < 300 && notes.size() > 0; i++) step(1);
    if (notes.size() > 0) begin
      num_errors++;
      $display("mismatch at %0t: notes left unchecked", $time);
    end
    wrap_up();
  end
endmodule : hot_plug_slot_power_control_tb

// File: sim/slot_host_model.sv
`timescale 1ns/1ps

module slot_host_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [4:0] want,
  input  wire logic       supplies_valid,
  output logic            power_indicator_enable,
  output logic            attention_indicator_enable,
  output logic            io_voltage_select,
  output logic            aux_power_switch,
  output logic            main_power_enable,
  output logic            system_power_good
);
  logic [5:0] held;
  logic [5:0] shown = 6'h00;

  assign {system_power_good, main_power_enable, aux_power_switch,
          io_voltage_select, attention_indicator_enable,
          power_indicator_enable} = shown;

  // Requests are taken at the edge and shown 1 ns later, so the slot
  // never samples a line in the middle of a change.
  always @(posedge clock or negedge rst_n) begin
    held = rst_n ? {supplies_valid, want} : 6'h00;
    #1;
    shown = held;
  end
endmodule : slot_host_model
